// ===== logic/dacli_host.sv
// Purpose: Host controller that loads the converter in serial or byte mode.
// Assumes: Software uses the plain register port; pins go straight to the converter.
// Notes: All pin outputs leave from one registered struct.
`timescale 1ns/1ps
`include "dacli_regs.svh"
module dacli_host #(
    parameter int LINK_DIV = `DACLI_LINK_DIV,
    parameter int RATE_W = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rd_data,
    input wire logic chain_out,
    output logic serial_select_n,
    output logic cs_strobe_n,
    output logic output_load_strobe,
    output logic upper_byte_enable_n,
    output logic lower_byte_enable_n,
    output logic async_zero_n,
    output logic [7:0] data_bus
);
    localparam int SETUP_CYC = (`DACLI_T_SETUP_NS * `DACLI_CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (`DACLI_T_STROBE_NS * `DACLI_CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (`DACLI_T_HOLD_NS * `DACLI_CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_SHIFT, ST_TAIL} dacli_state_t;

    // Command decode shared by the write path and the busy check.
    function automatic logic is_cmd(input logic [7:0] a);
        is_cmd = (a == `DACLI_OFS_LOW_BYTE) || (a == `DACLI_OFS_HIGH_BYTE) || (a == `DACLI_OFS_LOAD_A) ||
                 (a == `DACLI_OFS_LOAD_B) || (a == `DACLI_OFS_CLR_UNI) || (a == `DACLI_OFS_CLR_BIP);
    endfunction : is_cmd

    dacli_pkg::dacli_req_t req;
    dacli_pkg::dacli_pins_t pins_reg, pins_next;
    dacli_state_t state_reg, state_next;
    dacli_pkg::dacli_op_t op_reg, op_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [3:0] ctrl_reg, ctrl_next;
    logic [15:0] word_reg, word_next;
    logic [RATE_W-1:0] rate_reg, rate_next;
    logic [RATE_W-1:0] timer_reg, timer_next;
    logic dropped_reg, dropped_next;
    logic [31:0] rd_reg, rd_next;
    logic chain_meta_reg, chain_sync_reg;
    logic tick, sh_start, sh_cs, sh_sd, sh_busy, sh_done;
    logic serial_mode, timer_fire, cmd_wr, drop_evt, start_serial;

    assign req = '{addr: addr, wdata: wr_data, wr: wr_stb, rd: rd_stb};
    assign serial_mode = ctrl_reg[`DACLI_CTRL_SERIAL];

    dacli_clkdiv #(.DIV(LINK_DIV)) u_div (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(tick)
    );

    dacli_shifter #(.WIDTH(16)) u_shift (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(tick),
        .start(sh_start),
        .msb_first(ctrl_reg[`DACLI_CTRL_MSB_FIRST]),
        .word(word_reg),
        .cs_strobe_n(sh_cs),
        .serial_in(sh_sd),
        .busy(sh_busy),
        .done(sh_done)
    );

    // Chain output from the converter crosses in through two flops.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chain_meta_reg <= 1'b0;
            chain_sync_reg <= 1'b0;
        end else begin
            chain_meta_reg <= chain_out;
            chain_sync_reg <= chain_meta_reg;
        end
    end

    // Register file and periodic timer.
    always_comb begin
        ctrl_next = ctrl_reg;
        word_next = word_reg;
        rate_next = rate_reg;
        timer_next = timer_reg;
        dropped_next = dropped_reg;
        rd_next = 32'h0000_0000;
        timer_fire = 1'b0;
        cmd_wr = req.wr && is_cmd(req.addr);
        drop_evt = cmd_wr && (state_reg != ST_IDLE);
        if (req.wr) begin
            unique case (req.addr)
                `DACLI_OFS_CTRL: begin
                    // Mode bit only changes while no transfer runs.
                    if (state_reg == ST_IDLE) begin
                        ctrl_next = req.wdata[3:0];
                    end else begin
                        ctrl_next = {req.wdata[3:1], ctrl_reg[0]};
                    end
                end
                `DACLI_OFS_WORD: word_next = req.wdata[15:0];
                `DACLI_OFS_RATE: rate_next = req.wdata[RATE_W-1:0];
                `DACLI_OFS_STATUS: dropped_next = dropped_next & ~req.wdata[`DACLI_STAT_DROPPED];
                default: ;
            endcase
        end
        // A refused command while the clear arrives still marks the flag.
        if (drop_evt) begin
            dropped_next = 1'b1;
        end
        if (ctrl_reg[`DACLI_CTRL_TIMER_EN] && serial_mode) begin
            if (timer_reg == '0) begin
                timer_next = rate_reg;
                timer_fire = 1'b1;
            end else begin
                timer_next = timer_reg - 1'b1;
            end
        end else begin
            timer_next = rate_reg;
        end
        if (req.rd) begin
            unique case (req.addr)
                `DACLI_OFS_CTRL: rd_next = {28'h0000000, ctrl_reg};
                `DACLI_OFS_WORD: rd_next = {16'h0000, word_reg};
                `DACLI_OFS_RATE: rd_next = 32'(rate_reg);
                `DACLI_OFS_STATUS: rd_next = {29'h00000000, chain_sync_reg, dropped_reg, state_reg != ST_IDLE};
                default: rd_next = 32'h0000_0000;
            endcase
        end
    end

    // Pin sequencer.
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        cnt_next = cnt_reg;
        pins_next = pins_reg;
        sh_start = 1'b0;
        start_serial = 1'b0;
        pins_next.serial_select_n = serial_mode ? pins_reg.serial_select_n : 1'b1;
        unique case (state_reg)
            ST_IDLE: begin
                if (serial_mode) begin
                    pins_next.data_bus[1] = ctrl_reg[`DACLI_CTRL_MSB_FIRST];
                    pins_next.lower_byte_enable_n = ctrl_reg[`DACLI_CTRL_CLR_BIPOLAR];
                    pins_next.upper_byte_enable_n = 1'b1;
                end
                start_serial = serial_mode && (timer_fire || (req.wr &&
                               (req.addr == `DACLI_OFS_LOAD_A || req.addr == `DACLI_OFS_LOAD_B)));
                if (start_serial) begin
                    pins_next.serial_select_n = 1'b0;
                    pins_next.output_load_strobe = 1'b0;
                    sh_start = 1'b1;
                    state_next = ST_SHIFT;
                end else if (cmd_wr) begin
                    state_next = ST_SETUP;
                    cnt_next = 8'(SETUP_CYC - 1);
                    unique case (req.addr)
                        `DACLI_OFS_LOW_BYTE: begin
                            op_next = dacli_pkg::DACLI_OP_LOW;
                            pins_next.data_bus = req.wdata[7:0];
                        end
                        `DACLI_OFS_HIGH_BYTE: begin
                            op_next = dacli_pkg::DACLI_OP_HIGH;
                            pins_next.data_bus = req.wdata[7:0];
                        end
                        `DACLI_OFS_CLR_UNI: begin
                            op_next = dacli_pkg::DACLI_OP_CLEAR;
                            pins_next.lower_byte_enable_n = 1'b0;
                        end
                        `DACLI_OFS_CLR_BIP: begin
                            op_next = dacli_pkg::DACLI_OP_CLEAR;
                            pins_next.lower_byte_enable_n = 1'b1;
                        end
                        default: op_next = dacli_pkg::DACLI_OP_LOAD;
                    endcase
                    // Byte commands make no sense while the pins are in serial use.
                    if (serial_mode && (op_next == dacli_pkg::DACLI_OP_LOW || op_next == dacli_pkg::DACLI_OP_HIGH)) begin
                        state_next = ST_IDLE;
                        pins_next.data_bus = pins_reg.data_bus;
                    end
                end
            end
            ST_SETUP: begin
                if (cnt_reg == 8'h00) begin
                    state_next = ST_STROBE;
                    cnt_next = 8'(STROBE_CYC - 1);
                    unique case (op_reg)
                        dacli_pkg::DACLI_OP_LOW: pins_next.lower_byte_enable_n = 1'b0;
                        dacli_pkg::DACLI_OP_HIGH: pins_next.upper_byte_enable_n = 1'b0;
                        dacli_pkg::DACLI_OP_LOAD: pins_next.output_load_strobe = 1'b0;
                        dacli_pkg::DACLI_OP_CLEAR: pins_next.async_zero_n = 1'b0;
                    endcase
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            ST_STROBE: begin
                if (cnt_reg == 8'h00) begin
                    state_next = ST_HOLD;
                    cnt_next = 8'(HOLD_CYC - 1);
                    pins_next.upper_byte_enable_n = 1'b1;
                    pins_next.output_load_strobe = 1'b1;
                    pins_next.async_zero_n = 1'b1;
                    if (op_reg == dacli_pkg::DACLI_OP_LOW) begin
                        pins_next.lower_byte_enable_n = 1'b1;
                    end
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            ST_HOLD: begin
                if (cnt_reg == 8'h00) begin
                    state_next = ST_IDLE;
                    pins_next.lower_byte_enable_n = serial_mode ? ctrl_reg[`DACLI_CTRL_CLR_BIPOLAR] : 1'b1;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            ST_SHIFT: begin
                pins_next.cs_strobe_n = sh_cs;
                pins_next.data_bus[0] = sh_sd;
                // Select stays low across the last strobe rise so that the final bit is still taken.
                if (sh_done) begin
                    state_next = ST_TAIL;
                    cnt_next = 8'h01;
                end
            end
            ST_TAIL: begin
                pins_next.serial_select_n = 1'b1;
                if (tick) begin
                    if (cnt_reg == 8'h00) begin
                        pins_next.output_load_strobe = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            op_reg <= dacli_pkg::DACLI_OP_LOW;
            cnt_reg <= 8'h00;
            pins_reg <= '{serial_select_n: 1'b1, cs_strobe_n: 1'b1, output_load_strobe: 1'b1,
                          upper_byte_enable_n: 1'b1, lower_byte_enable_n: 1'b1, async_zero_n: 1'b1,
                          data_bus: 8'h00};
            ctrl_reg <= `DACLI_CTRL_RESET;
            word_reg <= `DACLI_WORD_RESET;
            rate_reg <= RATE_W'(`DACLI_RATE_RESET);
            timer_reg <= RATE_W'(`DACLI_RATE_RESET);
            dropped_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            cnt_reg <= cnt_next;
            pins_reg <= pins_next;
            ctrl_reg <= ctrl_next;
            word_reg <= word_next;
            rate_reg <= rate_next;
            timer_reg <= timer_next;
            dropped_reg <= dropped_next;
            rd_reg <= rd_next;
        end
    end

    assign rd_data = rd_reg;
    assign serial_select_n = pins_reg.serial_select_n;
    assign cs_strobe_n = pins_reg.cs_strobe_n;
    assign output_load_strobe = pins_reg.output_load_strobe;
    assign upper_byte_enable_n = pins_reg.upper_byte_enable_n;
    assign lower_byte_enable_n = pins_reg.lower_byte_enable_n;
    assign async_zero_n = pins_reg.async_zero_n;
    assign data_bus = pins_reg.data_bus;
endmodule : dacli_host

// ===== logic/dacli_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the converter load host.
// Assumes: Byte addressed register port, one 32-bit word per register.
// Notes: How the controller drives the converter pins is summarised below.
// How it works
// - Serial bit is set while chip-select is low, stable at its rising edge.
// - Word goes out as high byte then low byte when the MSB-first control bit is set, low byte first otherwise; eight pulses each.
// - Load strobe low during the word, driven high afterwards to latch it.
// - Serial-select is low for exactly one sixteen-bit word.
// - Chip-select acts as inverted shift clock so data is stable at rising edge.
// - Load strobe rises one chip-select cycle after serial-select returns high.
// - A fixed-rate timer may start each serial word for low jitter.
// - Commands act only on a write strobe; address bit selects low or high byte.
// - Write to address 0 loads low byte, address 1 loads high byte.
// - Write to address 2 or 3 pulses the load strobe.
// - Address 4 clears to unipolar zero, 5 to bipolar zero; data ignored.
`ifndef DACLI_REGS_SVH
`define DACLI_REGS_SVH

`define DACLI_OFS_LOW_BYTE 8'h00
`define DACLI_OFS_HIGH_BYTE 8'h04
`define DACLI_OFS_LOAD_A 8'h08
`define DACLI_OFS_LOAD_B 8'h0C
`define DACLI_OFS_CLR_UNI 8'h10
`define DACLI_OFS_CLR_BIP 8'h14
`define DACLI_OFS_CTRL 8'h20
`define DACLI_OFS_WORD 8'h24
`define DACLI_OFS_RATE 8'h28
`define DACLI_OFS_STATUS 8'h2C

`define DACLI_CTRL_SERIAL 0
`define DACLI_CTRL_MSB_FIRST 1
`define DACLI_CTRL_TIMER_EN 2
`define DACLI_CTRL_CLR_BIPOLAR 3

`define DACLI_STAT_BUSY 0
`define DACLI_STAT_DROPPED 1
`define DACLI_STAT_CHAIN 2

`define DACLI_CTRL_RESET 4'h0
`define DACLI_WORD_RESET 16'h0000
`define DACLI_RATE_RESET 16'h0FA0

`define DACLI_CLK_MHZ 100
`define DACLI_T_SETUP_NS 30
`define DACLI_T_STROBE_NS 50
`define DACLI_T_HOLD_NS 30
`define DACLI_LINK_DIV 6

`endif

// ===== logic/dacli_pkg.sv
// Purpose: Types shared by the converter load host.
// Assumes: Constants live in dacli_regs.svh.
// Notes: Pin bundle is registered as one struct in the top.
package dacli_pkg;

    typedef struct packed {
        logic serial_select_n;
        logic cs_strobe_n;
        logic output_load_strobe;
        logic upper_byte_enable_n;
        logic lower_byte_enable_n;
        logic async_zero_n;
        logic [7:0] data_bus;
    } dacli_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dacli_req_t;

    typedef enum logic [1:0] {
        DACLI_OP_LOW,
        DACLI_OP_HIGH,
        DACLI_OP_LOAD,
        DACLI_OP_CLEAR
    } dacli_op_t;

endpackage : dacli_pkg

// ===== logic/dacli_clkdiv.sv
// Purpose: One-cycle enable pulse every DIV clocks, pacing the serial link.
// Assumes: DIV is at least 2.
// Notes: Free running so ticks are evenly spaced.
`timescale 1ns/1ps
module dacli_clkdiv #(
    parameter int DIV = 6
) (
    input wire logic sys_clk,
    input wire logic srst,
    output logic tick
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        tick_next = (cnt_reg == 8'(DIV - 1));
        cnt_next = tick_next ? 8'h00 : cnt_reg + 8'h01;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule : dacli_clkdiv

// ===== logic/dacli_shifter.sv
// Purpose: Shifts one 16-bit word out on serial data with chip-select as strobe.
// Assumes: tick is a one-cycle enable; start only while idle.
// Notes: Two ticks per bit: data changes with the strobe low, strobe rises mid bit.
`timescale 1ns/1ps
module dacli_shifter #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic start,
    input wire logic msb_first,
    input wire logic [WIDTH-1:0] word,
    output logic cs_strobe_n,
    output logic serial_in,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] sh_reg, sh_next;
    logic [4:0] cnt_reg, cnt_next;
    logic phase_reg, phase_next;
    logic cs_reg, cs_next;
    logic sd_reg, sd_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic order_reg, order_next;

    always_comb begin
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        phase_next = phase_reg;
        cs_next = cs_reg;
        sd_next = sd_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        order_next = order_reg;
        if (start && !busy_reg) begin
            sh_next = word;
            order_next = msb_first;
            cnt_next = 5'h00;
            phase_next = 1'b0;
            busy_next = 1'b1;
        end else if (busy_reg && tick) begin
            if (!phase_reg) begin
                sd_next = order_reg ? sh_reg[WIDTH-1] : sh_reg[0];
                cs_next = 1'b0;
                phase_next = 1'b1;
            end else begin
                cs_next = 1'b1;
                phase_next = 1'b0;
                sh_next = order_reg ? {sh_reg[WIDTH-2:0], 1'b0} : {1'b0, sh_reg[WIDTH-1:1]};
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg == 5'(WIDTH - 1)) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sh_reg <= '0;
            cnt_reg <= 5'h00;
            phase_reg <= 1'b0;
            cs_reg <= 1'b1;
            sd_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            order_reg <= 1'b1;
        end else begin
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            cs_reg <= cs_next;
            sd_reg <= sd_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            order_reg <= order_next;
        end
    end

    assign cs_strobe_n = cs_reg;
    assign serial_in = sd_reg;
    assign busy = busy_reg;
    assign done = done_reg;
endmodule : dacli_shifter

// ===== dv/dacli_host_checker.sv
// Purpose: Pin timing checks for the converter load host.
// Assumes: One clock domain; default link divider.
// Notes: Bound into dacli_host below.
`timescale 1ns/1ps
module dacli_host_checker #(
    parameter int LINK_DIV = 6
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic serial_select_n,
    input wire logic cs_strobe_n,
    input wire logic output_load_strobe,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic async_zero_n,
    input wire logic [7:0] data_bus
);
    localparam int LOAD_MAX = 3 * LINK_DIV;
    logic cs_d_reg;
    logic cs_d_next;
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    always_comb begin
        cs_d_next = cs_strobe_n;
        bit_cnt_next = serial_select_n ? 5'h00 : bit_cnt_reg + {4'h0, cs_strobe_n & ~cs_d_reg};
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cs_d_reg <= 1'b1;
            bit_cnt_reg <= 5'h00;
        end else begin
            cs_d_reg <= cs_d_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_low5(sig);
        (!sig) [*5] ##1 sig;
    endsequence
    AST_HIGH_PULSE: assert property ($fell(upper_byte_enable_n) |-> s_low5(upper_byte_enable_n))
        else $error("upper enable pulse wrong");
    AST_LOW_PULSE: assert property ($fell(lower_byte_enable_n) |->
        s_low5(lower_byte_enable_n) or ##3 $fell(async_zero_n))
        else $error("lower enable pulse wrong");
    AST_CLR_PULSE: assert property ($fell(async_zero_n) |-> s_low5(async_zero_n))
        else $error("clear pulse wrong");
    AST_CLR_TARGET: assert property (!async_zero_n |->
        $stable(lower_byte_enable_n) && output_load_strobe && upper_byte_enable_n)
        else $error("clear target moved");
    AST_LOAD_PULSE: assert property ($fell(output_load_strobe) && serial_select_n |->
        s_low5(output_load_strobe))
        else $error("load pulse wrong");
    AST_FRAME_LOAD: assert property (!serial_select_n |-> !output_load_strobe)
        else $error("load high in frame");
    AST_LOAD_AFTER: assert property ($rose(serial_select_n) |->
        (!output_load_strobe) [*6] ##[1:LOAD_MAX] $rose(output_load_strobe))
        else $error("load rise late or early");
    AST_CS_IN_FRAME: assert property (!cs_strobe_n |-> !serial_select_n)
        else $error("strobe outside frame");
    AST_BIT_STABLE: assert property ($rose(cs_strobe_n) |-> $stable(data_bus[0]))
        else $error("bit moved at strobe rise");
    AST_FRAME_BITS: assert property ($rose(serial_select_n) |-> bit_cnt_reg == 5'h10)
        else $error("frame not sixteen bits");
endmodule : dacli_host_checker
bind dacli_host dacli_host_checker #(.LINK_DIV(LINK_DIV)) u_chk (.sys_clk(sys_clk), .srst(srst),
    .serial_select_n(serial_select_n), .cs_strobe_n(cs_strobe_n), .output_load_strobe(output_load_strobe),
    .upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
    .async_zero_n(async_zero_n), .data_bus(data_bus));

// ===== dv/dacli_dev_model.sv
// Purpose: Behavioural converter latches fed by the host pins.
// Assumes: No clock; latches react to pin changes.
// Notes: Zero codes are plain defaults.
`timescale 1ns/1ps
module dacli_dev_model #(
    parameter logic [15:0] UNI_ZERO = 16'h0000,
    parameter logic [15:0] BIP_ZERO = 16'h8000
) (
    input wire logic serial_select_n,
    input wire logic cs_strobe_n,
    input wire logic output_load_strobe,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic async_zero_n,
    input wire logic [7:0] data_bus,
    output logic chain_out
);
    logic [15:0] first_latch = 16'h0000;
    logic [15:0] dac_latch = 16'h0000;
    logic cs_last = 1'b1;
    assign chain_out = first_latch[15];
    always @(serial_select_n or cs_strobe_n or output_load_strobe or upper_byte_enable_n
             or lower_byte_enable_n or async_zero_n or data_bus) begin
        if (cs_strobe_n && !cs_last && !serial_select_n)
            first_latch = data_bus[1] ? {first_latch[14:0], data_bus[0]} : {data_bus[0], first_latch[15:1]};
        cs_last = cs_strobe_n;
        if (serial_select_n && !upper_byte_enable_n)
            first_latch[15:8] = data_bus;
        if (serial_select_n && !lower_byte_enable_n)
            first_latch[7:0] = data_bus;
        if (!async_zero_n)
            dac_latch = lower_byte_enable_n ? BIP_ZERO : UNI_ZERO;
        else if (!output_load_strobe)
            dac_latch = first_latch;
    end
endmodule : dacli_dev_model

// ===== dv/tb_dacli_host.sv
// Purpose: Register-level tests of the load host against the converter model.
// Assumes: Default link divider.
// Notes: Timer rate is set short to keep the run brief.
`timescale 1ns/1ps
`include "dacli_regs.svh"
module tb_dacli_host;
    logic sys_clk, srst, wr_stb, rd_stb, chain_out;
    logic [7:0] addr;
    logic [7:0] data_bus;
    logic [31:0] wr_data, rd_data, seen;
    logic serial_select_n, cs_strobe_n, output_load_strobe, upper_byte_enable_n, lower_byte_enable_n, async_zero_n;
    int errors = 0;
    int checks = 0;
    logic [7:0] r_adr [4] = '{`DACLI_OFS_CTRL, `DACLI_OFS_WORD, `DACLI_OFS_RATE, 8'h30};
    logic [31:0] r_exp [4] = '{32'h0, 32'h0, 32'h0FA0, 32'h0};
    logic [7:0] op_adr [5] = '{`DACLI_OFS_LOAD_A, `DACLI_OFS_CLR_UNI, `DACLI_OFS_LOAD_B, `DACLI_OFS_CLR_BIP, 8'h08};
    logic [15:0] op_exp [5] = '{16'hCDAB, 16'h0000, 16'hCDAB, 16'h8000, 16'hCDAB};
    logic [15:0] words [2] = '{16'hA5C3, 16'h1E87};
    dacli_host dut (.sys_clk(sys_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .chain_out(chain_out), .serial_select_n(serial_select_n),
        .cs_strobe_n(cs_strobe_n), .output_load_strobe(output_load_strobe), .upper_byte_enable_n(upper_byte_enable_n),
        .lower_byte_enable_n(lower_byte_enable_n), .async_zero_n(async_zero_n), .data_bus(data_bus));
    dacli_dev_model dev (.serial_select_n(serial_select_n), .cs_strobe_n(cs_strobe_n),
        .output_load_strobe(output_load_strobe), .upper_byte_enable_n(upper_byte_enable_n),
        .lower_byte_enable_n(lower_byte_enable_n), .async_zero_n(async_zero_n), .data_bus(data_bus),
        .chain_out(chain_out));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 seen = rd_data;
    endtask : rd
    task automatic wait_idle();
        for (int i = 0; i < 400; i++) begin
            rd(`DACLI_OFS_STATUS);
            if (seen[0] === 1'b0)
                return;
        end
        errors++;
        wrap_up();
    endtask : wait_idle
    initial begin
        srst = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(r_adr[i]);
            chk("reset reg", seen, r_exp[i]);
        end
        chk("idle pins", {18'h0, serial_select_n, cs_strobe_n, output_load_strobe, upper_byte_enable_n,
            lower_byte_enable_n, async_zero_n, data_bus}, 32'h3F00);
        $display("test reset done");
        wr(`DACLI_OFS_HIGH_BYTE, 32'hCD);
        wr(`DACLI_OFS_LOW_BYTE, 32'h11);
        wait_idle();
        rd(`DACLI_OFS_STATUS);
        chk("dropped flag", {31'h0, seen[1]}, 32'h1);
        chk("busy low byte", {16'h0, dev.first_latch}, 32'hCD00);
        wr(`DACLI_OFS_STATUS, 32'h2);
        rd(`DACLI_OFS_STATUS);
        chk("flag cleared", {31'h0, seen[1]}, 32'h0);
        wr(`DACLI_OFS_LOW_BYTE, 32'hAB);
        wait_idle();
        chk("first rank", {16'h0, dev.first_latch}, 32'hCDAB);
        chk("output kept", {16'h0, dev.dac_latch}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(op_adr[i], 32'hFFFF_FFFF);
            wait_idle();
            chk("output word", {16'h0, dev.dac_latch}, {16'h0, op_exp[i]});
        end
        chk("rank kept", {16'h0, dev.first_latch}, 32'hCDAB);
        $display("test byte done");
        for (int i = 0; i < 2; i++) begin
            wr(`DACLI_OFS_CTRL, (i == 0) ? 32'hB : 32'h9);
            wr(`DACLI_OFS_WORD, {16'h0, words[i]});
            wr(`DACLI_OFS_LOAD_A, 32'h0);
            wait_idle();
            chk("serial rank", {16'h0, dev.first_latch}, {16'h0, words[i]});
            chk("serial out", {16'h0, dev.dac_latch}, {16'h0, words[i]});
            rd(`DACLI_OFS_STATUS);
            chk("chain", {31'h0, seen[2]}, {31'h0, words[i][15]});
        end
        $display("test serial done");
        wr(`DACLI_OFS_RATE, 32'h12C);
        wr(`DACLI_OFS_WORD, 32'h0F0F);
        wr(`DACLI_OFS_CTRL, 32'hF);
        for (int i = 0; i <= 400; i++) begin
            @(posedge sys_clk);
            #1;
            if (serial_select_n === 1'b0)
                break;
            if (i == 400) begin
                errors++;
                wrap_up();
            end
        end
        wait_idle();
        chk("timer word", {16'h0, dev.dac_latch}, 32'h0F0F);
        $display("test timer done");
        wrap_up();
    end
endmodule : tb_dacli_host
